// File: tws_consts.svh
// Register offsets, field positions, reset values and status codes for the two-wire slave
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH
`define TWS_OFF_ADDR 12'h000
`define TWS_OFF_CTRL 12'h004
`define TWS_OFF_STAT 12'h008
`define TWS_OFF_DATA 12'h00C
`define TWS_OFF_PWR 12'h010
`define TWS_C_INT 7
`define TWS_C_EA 6
`define TWS_C_STA 5
`define TWS_C_STO 4
`define TWS_C_WC 3
`define TWS_C_EN 2
`define TWS_C_IE 0
`define TWS_ADDR_RST 8'h00
`define TWS_CTRL_RST 8'h00
`define TWS_DATA_RST 8'hFF
`define TWS_ST_SRX_ADR 8'h60
`define TWS_ST_SRX_ALADR 8'h68
`define TWS_ST_GC_ADR 8'h70
`define TWS_ST_GC_ALADR 8'h78
`define TWS_ST_SRX_ACK 8'h80
`define TWS_ST_SRX_NACK 8'h88
`define TWS_ST_GC_ACK 8'h90
`define TWS_ST_GC_NACK 8'h98
`define TWS_ST_STOP 8'hA0
`define TWS_ST_STX_ADR 8'hA8
`define TWS_ST_STX_ALADR 8'hB0
`define TWS_ST_STX_ACK 8'hB8
`define TWS_ST_STX_NACK 8'hC0
`define TWS_ST_STX_LAST 8'hC8
`define TWS_ST_IDLE 8'hF8
`define TWS_GC_ADDR 7'h00
`endif

// File: tws_pkg.sv
// Types for the two-wire slave block
`default_nettype none
package tws_pkg;
   // Link byte engine phases
   typedef enum logic [6:0] {
      TWS_IDLE = 7'b0000001,
      TWS_ADDR = 7'b0000010,
      TWS_RXB = 7'b0000100,
      TWS_RACK = 7'b0001000,
      TWS_TXB = 7'b0010000,
      TWS_TACK = 7'b0100000,
      TWS_HOLD = 7'b1000000
   } tws_phase_t;
   // Synchronised bus pins
   typedef struct packed {
      logic scl;
      logic sda;
   } tws_pins_t;
   // APB request group
   typedef struct packed {
      logic sel;
      logic en;
      logic wr;
      logic [11:0] addr;
      logic [31:0] wdata;
   } tws_apb_req_t;
endpackage : tws_pkg
`default_nettype wire

// File: tws_slave.sv
// Two-wire slave receiver/transmitter with APB register access
//
// Design decisions made here: the address map and the APB slave port.
`include "tws_consts.svh"
`default_nettype none
module tws_slave
   import tws_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic scl_oe,
   output logic sda_o,
   output logic sda_oe,
   input wire logic sleep_req,
   input wire logic arb_lost,
   output logic wake_req,
   output logic start_pending
);
   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; first stage read only by the second
   tws_pins_t s1_q, s2_q, s3_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_q <= 2'b11;
         s2_q <= 2'b11;
         s3_q <= 2'b11;
      end else begin
         s1_q <= '{scl: scl_i, sda: sda_i};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   logic scl_rise, scl_fall, start_det, stop_det;
   assign scl_rise = s2_q.scl & ~s3_q.scl;
   assign scl_fall = ~s2_q.scl & s3_q.scl;
   assign start_det = s2_q.scl & s3_q.scl & s3_q.sda & ~s2_q.sda;
   assign stop_det = s2_q.scl & s3_q.scl & ~s3_q.sda & s2_q.sda;

   ////////////////////////////////////////////////////////////////////////////
   // Register and link state
   tws_apb_req_t req;
   assign req = '{sel: psel, en: penable, wr: pwrite, addr: paddr, wdata: pwdata};
   logic [7:0] addr_q, addr_d, ctrl_q, ctrl_d, stat_q, stat_d;
   logic [7:0] data_q, data_d, sh_q, sh_d;
   logic [2:0] cnt_q, cnt_d;
   logic gc_q, gc_d, tx_q, tx_d, last_q, last_d, ign_q, ign_d, sda_q, sda_d, addr_ok_q;
   logic addr_ok_d, drv_q, drv_d, wake_q, wake_d, sta_q, sta_d;
   logic [31:0] rd_q, rd_d;
   logic rdy_q, rdy_d, err_q, err_d;
   tws_phase_t ph_q, ph_d;

   // Own-address or enabled general-call match on a 7-bit address
   function automatic logic addr_hit(input logic [6:0] a, input logic [7:0] own,
                                     input logic ea);
      addr_hit = ea & ((a == own[7:1]) | ((a == `TWS_GC_ADDR) & own[0]));
   endfunction : addr_hit

   logic access, wr_ctrl, flag_clr, flag_set;
   logic [7:0] set_code;
   assign access = req.sel & req.en & ~rdy_q;
   assign wr_ctrl = access & req.wr & (req.addr == `TWS_OFF_CTRL);
   assign flag_clr = wr_ctrl & req.wdata[`TWS_C_INT];

   ////////////////////////////////////////////////////////////////////////////
   // Link byte engine
   always_comb begin
      ph_d = ph_q;
      sh_d = sh_q;
      cnt_d = cnt_q;
      gc_d = gc_q;
      tx_d = tx_q;
      last_d = last_q;
      ign_d = ign_q;
      sda_d = sda_q;
      addr_ok_d = addr_ok_q;
      data_d = data_q;
      flag_set = 1'b0;
      set_code = `TWS_ST_IDLE;
      if (!ctrl_q[`TWS_C_EN]) begin
         ph_d = TWS_IDLE;
         sda_d = 1'b0;
         addr_ok_d = 1'b0;
      end else if (stop_det | start_det) begin
         // Stop or restart ends any addressed transfer
         if (addr_ok_q & ~ctrl_q[`TWS_C_INT] & ~tx_q) begin
            flag_set = 1'b1;
            set_code = `TWS_ST_STOP;
         end
         addr_ok_d = 1'b0;
         sda_d = 1'b0;
         ign_d = 1'b0;
         ph_d = start_det ? TWS_ADDR : TWS_IDLE;
         cnt_d = 3'h0;
      end else begin
         unique case (ph_q)
            TWS_IDLE: ;
            TWS_ADDR, TWS_RXB: if (scl_rise) begin
               sh_d = {sh_q[6:0], s2_q.sda};
               cnt_d = cnt_q + 3'h1;
               if (cnt_q == 3'h7) ph_d = (ph_q == TWS_ADDR) ? TWS_HOLD : TWS_RACK;
            end
            TWS_HOLD: if (scl_fall) begin
               // Address byte complete: decide at the eighth clock's low edge
               if (addr_hit(sh_q[7:1], addr_q, ctrl_q[`TWS_C_EA]) & ~ctrl_q[`TWS_C_INT]) begin
                  addr_ok_d = 1'b1;
                  gc_d = (sh_q[7:1] == `TWS_GC_ADDR);
                  tx_d = sh_q[0] & ~gc_d;
                  sda_d = 1'b1;
                  ph_d = TWS_RACK;
                  flag_set = 1'b1;
                  if (tx_d) set_code = arb_lost ? `TWS_ST_STX_ALADR : `TWS_ST_STX_ADR;
                  else if (gc_d) set_code = arb_lost ? `TWS_ST_GC_ALADR : `TWS_ST_GC_ADR;
                  else set_code = arb_lost ? `TWS_ST_SRX_ALADR : `TWS_ST_SRX_ADR;
               end else ph_d = TWS_IDLE; // Not ours; keep watching
            end
            TWS_RACK: if (tx_q & ~sda_q & addr_ok_q & ~ctrl_q[`TWS_C_INT]) begin
               // Flag cleared after an acked byte: the freshly loaded byte goes out
               cnt_d = 3'h0;
               ph_d = TWS_TXB;
               sh_d = data_q;
               last_d = ~ctrl_q[`TWS_C_EA];
               sda_d = ~data_q[7];
            end else if (scl_fall) begin
               if (sda_q) begin
                  // Ack bit finished: start next byte
                  sda_d = 1'b0;
                  cnt_d = 3'h0;
                  ph_d = tx_q ? TWS_TXB : TWS_RXB;
                  sh_d = data_q;
                  last_d = ~ctrl_q[`TWS_C_EA];
                  if (tx_q) sda_d = ~data_q[7];
               end else if (addr_ok_q & ~tx_q & ~ign_q) begin
                  // Received byte: ack per enable, hand to software
                  data_d = sh_q;
                  sda_d = ctrl_q[`TWS_C_EA];
                  flag_set = 1'b1;
                  set_code = gc_q ? (ctrl_q[`TWS_C_EA] ? `TWS_ST_GC_ACK : `TWS_ST_GC_NACK)
                                  : (ctrl_q[`TWS_C_EA] ? `TWS_ST_SRX_ACK : `TWS_ST_SRX_NACK);
                  // Not-acked byte leaves the addressed state, so a later stop sets no A0
                  if (!ctrl_q[`TWS_C_EA]) begin
                     ign_d = 1'b1;
                     addr_ok_d = 1'b0;
                  end
                  cnt_d = 3'h0;
                  ph_d = ctrl_q[`TWS_C_EA] ? TWS_RACK : TWS_RXB;
               end else ph_d = TWS_IDLE;
            end
            TWS_TXB: if (scl_fall) begin
               cnt_d = cnt_q + 3'h1;
               sh_d = {sh_q[6:0], 1'b1};
               sda_d = ~sh_q[6];
               if (cnt_q == 3'h7) begin
                  sda_d = 1'b0;
                  ph_d = TWS_TACK;
               end
            end
            TWS_TACK: if (scl_fall) begin
               // Judged at the low edge: a stretch raised while high would cut the clock
               flag_set = 1'b1;
               ph_d = TWS_RACK;
               sda_d = 1'b0;
               if (s2_q.sda) begin
                  set_code = `TWS_ST_STX_NACK;
                  addr_ok_d = 1'b0;
               end else if (last_q) begin
                  set_code = `TWS_ST_STX_LAST;
                  addr_ok_d = 1'b0;
               end else set_code = `TWS_ST_STX_ACK;
               if (s2_q.sda | last_q) ph_d = TWS_IDLE; // Master reads all ones now
            end
            default: ph_d = TWS_IDLE;
         endcase
      end
      if (access & req.wr & (req.addr == `TWS_OFF_DATA)) data_d = req.wdata[7:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers, status and clock stretch
   always_comb begin
      addr_d = addr_q;
      ctrl_d = ctrl_q;
      stat_d = stat_q;
      drv_d = ctrl_q[`TWS_C_INT] & addr_ok_q; // Hold SCL while software works
      wake_d = wake_q;
      sta_d = sta_q;
      rd_d = 32'h0000_0000;
      rdy_d = access;
      err_d = 1'b0;
      if (access & req.wr) begin
         unique case (req.addr)
            `TWS_OFF_ADDR: addr_d = req.wdata[7:0];
            `TWS_OFF_CTRL: ctrl_d = {ctrl_q[7], req.wdata[6:4], ctrl_q[3], req.wdata[2:0]};
            `TWS_OFF_DATA: ctrl_d[`TWS_C_WC] = ctrl_q[`TWS_C_INT];
            `TWS_OFF_STAT, `TWS_OFF_PWR: ;
            default: err_d = 1'b1;
         endcase
      end else if (access) begin
         unique case (req.addr)
            `TWS_OFF_ADDR: rd_d = {24'h00_0000, addr_q};
            `TWS_OFF_CTRL: rd_d = {24'h00_0000, ctrl_q};
            `TWS_OFF_STAT: rd_d = {24'h00_0000, stat_q}; // Prescaler bits read zero
            `TWS_OFF_DATA: rd_d = {24'h00_0000, data_q};
            `TWS_OFF_PWR: rd_d = {30'h0000_0000, wake_q, sta_q};
            default: err_d = 1'b1;
         endcase
      end
      if (flag_clr) begin
         ctrl_d[`TWS_C_INT] = 1'b0;
         stat_d = `TWS_ST_IDLE;
         wake_d = 1'b0;
         if (!addr_ok_q) sta_d = ctrl_d[`TWS_C_STA]; // Start when bus frees
      end
      // Set wins over a same-cycle clear
      if (flag_set) begin
         ctrl_d[`TWS_C_INT] = 1'b1;
         stat_d = set_code;
         if (sleep_req) wake_d = 1'b1;
      end
      if (stop_det) sta_d = 1'b0;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ph_q <= TWS_IDLE;
         addr_q <= `TWS_ADDR_RST;
         ctrl_q <= `TWS_CTRL_RST;
         stat_q <= `TWS_ST_IDLE;
         data_q <= `TWS_DATA_RST;
         sh_q <= 8'h00;
         cnt_q <= 3'h0;
         gc_q <= 1'b0;
         tx_q <= 1'b0;
         last_q <= 1'b0;
         ign_q <= 1'b0;
         sda_q <= 1'b0;
         addr_ok_q <= 1'b0;
         drv_q <= 1'b0;
         wake_q <= 1'b0;
         sta_q <= 1'b0;
         rd_q <= 32'h0000_0000;
         rdy_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         ph_q <= ph_d;
         addr_q <= addr_d;
         ctrl_q <= ctrl_d;
         stat_q <= stat_d;
         data_q <= data_d;
         sh_q <= sh_d;
         cnt_q <= cnt_d;
         gc_q <= gc_d;
         tx_q <= tx_d;
         last_q <= last_d;
         ign_q <= ign_d;
         sda_q <= sda_d;
         addr_ok_q <= addr_ok_d;
         drv_q <= drv_d;
         wake_q <= wake_d;
         sta_q <= sta_d;
         rd_q <= rd_d;
         rdy_q <= rdy_d;
         err_q <= err_d;
      end
   end

   // Open-drain outputs: only ever pull low
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe = drv_q;
   assign sda_oe = sda_q;
   assign prdata = rd_q;
   assign pready = rdy_q;
   assign pslverr = err_q;
   assign wake_req = wake_q;
   assign start_pending = sta_q;
endmodule : tws_slave
`default_nettype wire

// File: tws_checker.sv
// Port assertions for the two-wire slave
`include "tws_consts.svh"
`default_nettype none
module tws_checker
   import tws_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic scl_o,
   input wire logic sda_o,
   input wire logic scl_oe,
   input wire logic sleep_req,
   input wire logic wake_req
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // Steps: access waiting, read answer, wake event
   sequence s_req;
      psel && penable && !pready;
   endsequence
   sequence s_rd;
      pready && !pwrite;
   endsequence
   sequence s_wake;
      $rose(wake_req);
   endsequence
   // Bus answers
   property p_one_wait;
      s_req |=> pready;
   endproperty
   property p_rdy_pulse;
      pready |=> !pready;
   endproperty
   property p_err_map;
      pready |-> pslverr == (paddr > `TWS_OFF_PWR);
   endproperty
   property p_rd_upper;
      s_rd |-> prdata[31:8] == 24'h000000;
   endproperty
   property p_stat_pres;
      s_rd ##0 paddr == `TWS_OFF_STAT |-> prdata[2:0] == 3'h0;
   endproperty
   // Pins only ever pull low; wake only from sleep, clock then held
   property p_open_drain;
      !scl_o && !sda_o;
   endproperty
   property p_wake_sleep;
      s_wake |-> $past(sleep_req);
   endproperty
   property p_wake_hold;
      s_wake |-> ##[0:8] scl_oe;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("pready late");
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready held");
   a_err_map: assert property (p_err_map) else $error("pslverr wrong");
   a_rd_upper: assert property (p_rd_upper) else $error("upper bits set");
   a_stat_pres: assert property (p_stat_pres) else $error("prescaler bits set");
   a_open_drain: assert property (p_open_drain) else $error("pin driven high");
   a_wake_sleep: assert property (p_wake_sleep) else $error("wake while awake");
   a_wake_hold: assert property (p_wake_hold) else $error("clock not held");
endmodule : tws_checker
bind tws_slave tws_checker u_chk (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .scl_o(scl_o), .sda_o(sda_o), .scl_oe(scl_oe), .sleep_req(sleep_req), .wake_req(wake_req));
`default_nettype wire

// File: tws_master.sv
// Two-wire bus master model, pull-ups on both lines
`default_nettype none
module tws_master (
   input wire logic clk,
   input wire logic scl_oe,
   input wire logic sda_oe,
   output logic scl,
   output logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   logic scl_lo = 1'b0;
   logic sda_lo = 1'b0;
   int tmo = 0;
   // Wired-AND: a released line floats high
   assign scl = !(scl_lo || scl_oe);
   assign sda = !(sda_lo || sda_oe);
   ////////////////////////////////////////
   // Quarter of the 160 ns bit
   task automatic q;
      repeat (8) @(posedge clk);
   endtask : q
   // Release clock, wait out stretching
   task automatic hi;
      int n;
      n = 0;
      scl_lo <= 1'b0;
      q();
      while (!scl && n < 50000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 50000) tmo++;
   endtask : hi
   task automatic wb(input logic b);
      sda_lo <= !b;
      q();
      hi();
      q();
      scl_lo <= 1'b1;
      q();
   endtask : wb
   // Released data line while the slave talks
   task automatic rb(output logic b);
      sda_lo <= 1'b0;
      q();
      hi();
      b = sda;
      q();
      scl_lo <= 1'b1;
      q();
   endtask : rb
   task automatic wr(input logic [7:0] d, output logic nak);
      for (int i = 7; i >= 0; i--) wb(d[i]);
      rb(nak);
   endtask : wr
   task automatic rd(output logic [7:0] d, input logic nak);
      for (int i = 7; i >= 0; i--) rb(d[i]);
      wb(nak);
   endtask : rd
   task automatic adr(input logic [7:0] d, output logic nak);
      sda_lo <= 1'b1;
      q();
      scl_lo <= 1'b1;
      q();
      wr(d, nak);
   endtask : adr
   task automatic stop;
      sda_lo <= 1'b1;
      q();
      hi();
      q();
      sda_lo <= 1'b0;
      q();
   endtask : stop
endmodule : tws_master
`default_nettype wire

// File: tb_top.sv
// Bench: registers, transmit, general call, isolation, wake
`include "tws_consts.svh"
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
$display("mismatch at %0t: %h, expected %h", $time, a, b); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic w; logic [11:0] a; logic [7:0] d; logic [7:0] x; logic er;} tws_row_t;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic sleep_req = 1'b0;
   logic arb_lost = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, r;
   logic pready, pslverr, e, a, scl_o, scl_oe, sda_o, sda_oe, wake_req, start_pending, scl, sda;
   logic [7:0] d;
   int error_cnt = 0;
   int n_compared = 0;
   int n;
   tws_row_t rows [11] = '{{1'b0, `TWS_OFF_ADDR, 8'h00, `TWS_ADDR_RST, 1'b0},
      {1'b0, `TWS_OFF_CTRL, 8'h00, `TWS_CTRL_RST, 1'b0}, {1'b0, `TWS_OFF_STAT, 8'h00, 8'hF8, 1'b0},
      {1'b0, `TWS_OFF_DATA, 8'h00, `TWS_DATA_RST, 1'b0}, {1'b0, `TWS_OFF_PWR, 8'h00, 8'h00, 1'b0},
      {1'b1, 12'h014, 8'h5A, 8'h00, 1'b1}, {1'b0, 12'h014, 8'h00, 8'h00, 1'b1},
      {1'b1, `TWS_OFF_ADDR, 8'h55, 8'h00, 1'b0}, {1'b0, `TWS_OFF_ADDR, 8'h00, 8'h55, 1'b0},
      {1'b1, `TWS_OFF_CTRL, 8'h44, 8'h00, 1'b0}, {1'b0, `TWS_OFF_CTRL, 8'h00, 8'h44, 1'b0}};
   tws_slave u_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .scl_i(scl), .sda_i(sda), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe),
      .sleep_req(sleep_req), .arb_lost(arb_lost), .wake_req(wake_req),
      .start_pending(start_pending));
   tws_master u_mst (.clk(clk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda));
   // 200 MHz clock
   always #2.5 clk = ~clk;
   ////////////////////////////////////////
   // APB cycle: hold request until pready seen at an edge
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd,
      output logic [31:0] rd, output logic er);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && k < 100) begin
         @(posedge clk);
         k++;
      end
      if (k >= 100) error_cnt++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Software: wait for flag, check status, load data, write control
   task automatic svc(input logic [7:0] st, input logic [7:0] ct, input logic ld, input logic [7:0] dt);
      int k;
      k = 0;
      r = 32'h0;
      while (r[7] !== 1'b1 && k < 2000) begin
         apb(1'b0, `TWS_OFF_CTRL, 32'h0, r, e);
         k++;
      end
      apb(1'b0, `TWS_OFF_STAT, 32'h0, r, e);
      `CHK(r[7:0], st)
      if (ld) apb(1'b1, `TWS_OFF_DATA, {24'h0, dt}, r, e);
      apb(1'b1, `TWS_OFF_CTRL, {24'h0, ct}, r, e);
   endtask : svc
   task automatic results;
      $display("compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, {24'h0, rows[i].d}, r, e);
         `CHK(e, rows[i].er)
         if (!rows[i].w && !rows[i].er) `CHK(r, {24'h0, rows[i].x})
      end
      fork
         begin
            u_mst.adr(8'h55, a);
            `CHK(a, 1'b0)
            u_mst.rd(d, 1'b0);
            `CHK(d, 8'h3C)
            u_mst.rd(d, 1'b0);
            `CHK(d, 8'hA5)
            u_mst.rd(d, 1'b1);
            `CHK(d, 8'hFF)
            u_mst.stop();
         end
         begin
            svc(`TWS_ST_STX_ADR, 8'hC4, 1'b1, 8'h3C);
            svc(`TWS_ST_STX_ACK, 8'h84, 1'b1, 8'hA5);
            svc(`TWS_ST_STX_LAST, 8'hC4, 1'b0, 8'h00);
         end
      join
      apb(1'b0, `TWS_OFF_STAT, 32'h0, r, e);
      `CHK(r, 32'hF8)
      fork
         begin
            u_mst.adr(8'h00, a);
            `CHK(a, 1'b0)
            u_mst.wr(8'h11, a);
            `CHK(a, 1'b0)
            u_mst.wr(8'h22, a);
            `CHK(a, 1'b1)
            u_mst.stop();
         end
         begin
            svc(`TWS_ST_GC_ADR, 8'hC4, 1'b0, 8'h00);
            svc(`TWS_ST_GC_ACK, 8'h84, 1'b0, 8'h00);
            apb(1'b0, `TWS_OFF_DATA, 32'h0, r, e);
            `CHK(r, 32'h11)
            svc(`TWS_ST_GC_NACK, 8'hC4, 1'b0, 8'h00);
         end
      join
      // Ack enable low isolates; then general call off, neighbour address
      apb(1'b1, `TWS_OFF_CTRL, 32'h04, r, e);
      u_mst.adr(8'h55, a);
      `CHK(a, 1'b1)
      u_mst.stop();
      apb(1'b1, `TWS_OFF_CTRL, 32'h44, r, e);
      apb(1'b1, `TWS_OFF_ADDR, 32'h54, r, e);
      for (int i = 0; i < 2; i++) begin
         u_mst.adr(i ? 8'h56 : 8'h00, a);
         `CHK(a, 1'b1)
         u_mst.stop();
      end
      arb_lost <= 1'b1;
      fork
         begin
            u_mst.adr(8'h55, a);
            u_mst.rd(d, 1'b1);
            `CHK(d, 8'h77)
            u_mst.stop();
         end
         begin
            svc(`TWS_ST_STX_ALADR, 8'hC4, 1'b1, 8'h77);
            svc(`TWS_ST_STX_NACK, 8'hC4, 1'b0, 8'h00);
         end
      join
      arb_lost <= 1'b0;
      // Asleep: match on bus clock, clock held until flag cleared
      sleep_req <= 1'b1;
      fork
         begin
            u_mst.adr(8'h54, a);
            `CHK(a, 1'b0)
            u_mst.stop();
         end
         begin
            n = 0;
            while (wake_req !== 1'b1 && n < 20000) begin
               @(posedge clk);
               n++;
            end
            `CHK(wake_req, 1'b1)
            repeat (160) @(posedge clk);
            `CHK(scl, 1'b0)
            sleep_req <= 1'b0;
            svc(`TWS_ST_SRX_ADR, 8'hC4, 1'b0, 8'h00);
            apb(1'b0, `TWS_OFF_PWR, 32'h0, r, e);
            `CHK(r, 32'h0)
            svc(`TWS_ST_STOP, 8'hC4, 1'b0, 8'h00);
         end
      join
      // Second reset mid-run
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      apb(1'b0, `TWS_OFF_ADDR, 32'h0, r, e);
      `CHK(r, {24'h0, `TWS_ADDR_RST})
      error_cnt += u_mst.tmo;
      results();
   end
   // Watchdog, far beyond the expected run
   initial begin
      #500000;
      error_cnt++;
      results();
   end
endmodule : tb_top
`default_nettype wire
